// ==== verilog/sbc_port_engine.sv ====
// Audio port, configuration checker and register slave of the assisted subband codec engine.
`timescale 1ns/1ps
// Summary of operation
// R01: As master with idle period, channel data must finish before clock idle starts; checked on channel writes only, not when idle_start is written.
// R02: Port works on rising or falling bit-clock edge; sync and data may be inverted.
// R03: Falling mode, codec master: sync changes on falling edge, sampled on next rising.
// R04: Falling mode captures incoming serial data on the falling bit-clock edge.
// R05: Both channels have independent word size and arbitrary bit position in frame.
// R06: Only one of low-energy, wideband speech and streaming may be active.
// R07: Wideband speech uses mono, 16 kHz, loudness, 8 subbands, block 15, bitpool 26; block length is not checked.
// R08: Wideband speech allows one wideband connection and never a narrowband one too.
// R09: Streaming sink and source accept only the subband coding scheme.
// R10: Streaming accepts mono, dual channel, stereo and joint stereo.
// R11: Streaming accepts sampling at 16, 44.1 and 48 kHz.
// R12: Streaming accepts block lengths 4, 8, 12, 16 and 4 or 8 subbands.
// R13: Streaming accepts signal-to-noise and loudness allocation.
// R14: Bitpool range is 2 to 54 for sink and 2 to 57 for source.
// R15: Transfer unit size is 260 to 800 bytes sink, 260 to 1021 source.
// R16: Configuring party should prefer block 16, loudness, 8 subbands, table bitpool.
// R17: Out-of-range codec settings are refused, flagged, and old settings kept.
// R18: Source encodes samples taken from the port; sink delivers decoded samples on it.
module sbc_port_engine (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic pcm_clk_in,
  output logic pcm_clk_out,
  output logic pcm_clk_oe,
  input wire logic pcm_sync_in,
  output logic pcm_sync_out,
  output logic pcm_sync_oe,
  input wire logic pcm_data_in,
  output logic pcm_data_out,
  output logic pcm_data_oe,
  output logic [31:0] enc_sample_data,
  output logic enc_sample_chan,
  output logic enc_sample_valid,
  input wire logic [31:0] dec_sample_data,
  input wire logic dec_sample_chan,
  input wire logic dec_sample_valid,
  output sbc_port_pkg::codec_cfg_type codec_cfg,
  output logic [10:0] mtu_size
);
  // ==========================================================================
  // Bus slave
  logic [7:0] addr_reg;
  logic wr_pend_reg;
  logic rd_pend_reg;
  logic rd_wait_reg;
  logic [31:0] rdata_reg;
  sbc_port_pkg::port_cfg_type pcfg_reg;
  sbc_port_pkg::port_time_type ptime_reg;
  sbc_port_pkg::chan_cfg_type ch_reg [2];
  sbc_port_pkg::codec_cfg_type codec_reg;
  logic [10:0] mtu_reg;
  logic err_reg;
  logic wb_conn_reg;
  logic nb_conn_reg;
  logic [31:0] rx_reg [2];
  logic [31:0] tx_reg [2];
  wire addr_take = hsel & htrans[1] & hready;
  wire wr_strobe = wr_pend_reg;
  wire wr_port = wr_strobe && addr_reg == sbc_port_pkg::port_cfg_off;
  wire wr_time = wr_strobe && addr_reg == sbc_port_pkg::port_time_off;
  wire wr_ch0 = wr_strobe && addr_reg == sbc_port_pkg::ch0_cfg_off;
  wire wr_ch1 = wr_strobe && addr_reg == sbc_port_pkg::ch1_cfg_off;
  wire wr_codec = wr_strobe && addr_reg == sbc_port_pkg::codec_cfg_off;
  wire wr_mtu = wr_strobe && addr_reg == sbc_port_pkg::mtu_off;
  wire wr_status = wr_strobe && addr_reg == sbc_port_pkg::status_off;
  wire wr_tx0 = wr_strobe && addr_reg == sbc_port_pkg::tx0_off;
  wire wr_tx1 = wr_strobe && addr_reg == sbc_port_pkg::tx1_off;
  wire wr_link = wr_strobe && addr_reg == sbc_port_pkg::link_off;
  // ==========================================================================
  // Configuration checks
  sbc_port_pkg::codec_cfg_type new_codec;
  sbc_port_pkg::chan_cfg_type new_ch;
  assign new_codec = hwdata[19:0];
  assign new_ch = {hwdata[15:8], hwdata[5:0]};
  wire [2:0] cur_func = codec_reg.func;
  wire func_switch_ok = new_codec.func == sbc_port_pkg::func_none ||
    cur_func == sbc_port_pkg::func_none || new_codec.func == cur_func; // R06
  wire func_known = new_codec.func <= sbc_port_pkg::func_source;
  wire wbs_ok = new_codec.chmode == sbc_port_pkg::chmode_mono &&
    new_codec.fs == sbc_port_pkg::fs_16k && new_codec.alloc == sbc_port_pkg::alloc_loudness &&
    new_codec.sub == sbc_port_pkg::sub_8 && new_codec.bitpool == sbc_port_pkg::wbs_bitpool; // R07
  wire is_sink = new_codec.func == sbc_port_pkg::func_sink;
  wire [7:0] pool_max = is_sink ? sbc_port_pkg::bitpool_max_sink :
    sbc_port_pkg::bitpool_max_source; // R14
  // Channel mode, block length, subbands and allocation are 2- and 1-bit fields whose
  // every code is a supported value, so only sampling rate needs a range test.
  wire stream_ok = new_codec.scheme == sbc_port_pkg::scheme_sbc && // R09
    new_codec.fs <= sbc_port_pkg::fs_48k && // R11 R10 R12 R13
    new_codec.bitpool >= sbc_port_pkg::bitpool_min && new_codec.bitpool <= pool_max; // R14
  wire is_stream = is_sink || new_codec.func == sbc_port_pkg::func_source;
  wire codec_ok = func_known && func_switch_ok &&
    (new_codec.func == sbc_port_pkg::func_wbs ? wbs_ok : (!is_stream || stream_ok));
  wire [10:0] new_mtu = hwdata[10:0];
  wire [10:0] mtu_max = cur_func == sbc_port_pkg::func_sink ? sbc_port_pkg::mtu_max_sink :
    sbc_port_pkg::mtu_max_source;
  wire mtu_ok = new_mtu >= sbc_port_pkg::mtu_min && new_mtu <= mtu_max; // R15
  wire [8:0] new_ch_end = {1'b0, new_ch.pos} + {3'b000, new_ch.size};
  wire idle_on = ptime_reg.idle_start != 8'h00;
  wire ch_ok = new_ch.size != 6'h00 && new_ch.size <= sbc_port_pkg::word_max &&
    (!idle_on || new_ch_end <= {1'b0, ptime_reg.idle_start}); // R01 R05
  // A narrowband request is refused in wideband mode, as is a second wideband one.
  wire wbs_mode = cur_func == sbc_port_pkg::func_wbs;
  wire link_ok = !wbs_mode || (!hwdata[1] && !(hwdata[0] && wb_conn_reg)); // R08
  wire cfg_fault = (wr_codec && !codec_ok) || (wr_mtu && !mtu_ok) ||
    ((wr_ch0 || wr_ch1) && !ch_ok) || (wr_link && !link_ok); // R17
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      addr_reg <= 8'h00;
      wr_pend_reg <= 1'b0;
      rd_pend_reg <= 1'b0;
      rd_wait_reg <= 1'b0;
    end else begin
      wr_pend_reg <= addr_take & hwrite;
      rd_pend_reg <= addr_take & ~hwrite;
      rd_wait_reg <= rd_pend_reg;
      if (addr_take) begin
        addr_reg <= {haddr[7:2], 2'b00};
      end
    end
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pcfg_reg <= '{clk_div: sbc_port_pkg::clk_div_reset, default: 1'b0};
      ptime_reg <= '{frame_len: sbc_port_pkg::frame_len_reset, default: 8'h00};
      codec_reg <= '0;
      mtu_reg <= sbc_port_pkg::mtu_min;
      wb_conn_reg <= 1'b0;
      nb_conn_reg <= 1'b0;
      ch_reg[0] <= '{pos: 8'h00, size: 6'h10};
      ch_reg[1] <= '{pos: 8'h10, size: 6'h10};
    end else begin
      if (wr_port) pcfg_reg <= {hwdata[15:8], hwdata[4:0]}; // R02
      if (wr_time) ptime_reg <= hwdata[23:0];
      if (wr_ch0 && ch_ok) ch_reg[0] <= new_ch; // R05
      if (wr_ch1 && ch_ok) ch_reg[1] <= new_ch; // R05
      if (wr_codec && codec_ok) codec_reg <= new_codec; // R17
      if (wr_mtu && mtu_ok) mtu_reg <= new_mtu; // R17
      if (wr_link && link_ok) begin
        wb_conn_reg <= hwdata[0];
        nb_conn_reg <= hwdata[1];
      end else if (wr_codec && codec_ok && new_codec.func == sbc_port_pkg::func_wbs) begin
        nb_conn_reg <= 1'b0; // R08
      end
    end
  end
  // Error flag: hardware set wins over a write-one clear in the same cycle.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      err_reg <= 1'b0;
    end else if (cfg_fault) begin
      err_reg <= 1'b1; // R17
    end else if (wr_status && hwdata[0]) begin
      err_reg <= 1'b0;
    end
  end
  // ==========================================================================
  // Read path, one wait state so a write just ahead is always seen
  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = 32'h0000_0000;
    if (addr_reg == sbc_port_pkg::port_cfg_off) rd_mux = {16'h0000, pcfg_reg.clk_div, 3'b000,
      pcfg_reg.data_inv, pcfg_reg.sync_inv, pcfg_reg.falling, pcfg_reg.master, pcfg_reg.enable};
    else if (addr_reg == sbc_port_pkg::port_time_off) rd_mux = {8'h00, ptime_reg};
    else if (addr_reg == sbc_port_pkg::ch0_cfg_off) rd_mux = {16'h0000, ch_reg[0].pos, 2'b00,
      ch_reg[0].size};
    else if (addr_reg == sbc_port_pkg::ch1_cfg_off) rd_mux = {16'h0000, ch_reg[1].pos, 2'b00,
      ch_reg[1].size};
    else if (addr_reg == sbc_port_pkg::codec_cfg_off) rd_mux = {12'h000, codec_reg};
    else if (addr_reg == sbc_port_pkg::mtu_off) rd_mux = {21'h000000, mtu_reg};
    else if (addr_reg == sbc_port_pkg::status_off) rd_mux = {23'h000000, wb_conn_reg,
      1'b0, cur_func, 3'b000, err_reg};
    else if (addr_reg == sbc_port_pkg::rx0_off) rd_mux = rx_reg[0];
    else if (addr_reg == sbc_port_pkg::rx1_off) rd_mux = rx_reg[1];
    else if (addr_reg == sbc_port_pkg::tx0_off) rd_mux = tx_reg[0];
    else if (addr_reg == sbc_port_pkg::tx1_off) rd_mux = tx_reg[1];
    else if (addr_reg == sbc_port_pkg::link_off) rd_mux = {30'h00000000, nb_conn_reg,
      wb_conn_reg};
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rdata_reg <= 32'h0000_0000;
    end else if (rd_pend_reg) begin
      rdata_reg <= rd_mux;
    end
  end
  assign hrdata = rdata_reg;
  assign hreadyout = ~(rd_pend_reg & ~rd_wait_reg);
  assign hresp = 1'b0;
  assign codec_cfg = codec_reg;
  assign mtu_size = mtu_reg;
  // ==========================================================================
  // Pin synchronisers and edge events
  logic [1:0] clk_sync_reg;
  logic [1:0] fs_sync_reg;
  logic [1:0] din_sync_reg;
  logic clk_prev_reg;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      clk_sync_reg <= 2'b00;
      fs_sync_reg <= 2'b00;
      din_sync_reg <= 2'b00;
      clk_prev_reg <= 1'b0;
    end else begin
      clk_sync_reg <= {clk_sync_reg[0], pcm_clk_in};
      fs_sync_reg <= {fs_sync_reg[0], pcm_sync_in};
      din_sync_reg <= {din_sync_reg[0], pcm_data_in};
      clk_prev_reg <= clk_sync_reg[1];
    end
  end
  // Master clock: a divider gives a half-period enable, so the bit clock tops out at hclk/2.
  logic [7:0] div_cnt_reg;
  logic phase_reg;
  wire div_tick = pcfg_reg.enable && pcfg_reg.master &&
    div_cnt_reg + 8'h01 >= pcfg_reg.clk_div;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      div_cnt_reg <= 8'h00;
      phase_reg <= 1'b0;
    end else if (div_tick) begin
      div_cnt_reg <= 8'h00;
      phase_reg <= ~phase_reg;
    end else if (pcfg_reg.enable && pcfg_reg.master) begin
      div_cnt_reg <= div_cnt_reg + 8'h01;
    end
  end
  wire slv_on = pcfg_reg.enable && !pcfg_reg.master;
  wire rise_ev = div_tick ? !phase_reg : (slv_on && clk_sync_reg[1] && !clk_prev_reg);
  wire fall_ev = div_tick ? phase_reg : (slv_on && !clk_sync_reg[1] && clk_prev_reg);
  wire cap_ev = pcfg_reg.falling ? fall_ev : rise_ev; // R02 R04
  wire launch_ev = pcfg_reg.falling ? rise_ev : fall_ev; // R02
  wire sync_seen = fs_sync_reg[1] ^ pcfg_reg.sync_inv; // R02
  wire din_bit = din_sync_reg[1] ^ pcfg_reg.data_inv; // R02
  // ==========================================================================
  // Frame bit timer: sync is always taken on a rising edge, as a falling-edge codec needs.
  logic [7:0] frame_bit_timer;
  logic [7:0] timer_next;
  wire timer_wrap = frame_bit_timer + 8'h01 >= ptime_reg.frame_len;
  always_comb begin
    timer_next = frame_bit_timer + 8'h01;
    if (pcfg_reg.master ? timer_wrap : sync_seen) timer_next = 8'h00; // R03
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      frame_bit_timer <= 8'h00;
    end else if (!pcfg_reg.enable) begin
      frame_bit_timer <= 8'h00;
    end else if (rise_ev) begin
      frame_bit_timer <= timer_next; // R03
    end
  end
  // In rising mode capture shares the edge that moves the timer, so it sees the new count.
  wire [7:0] cap_idx = rise_ev ? timer_next : frame_bit_timer;
  wire in_idle = idle_on && frame_bit_timer >= ptime_reg.idle_start &&
    frame_bit_timer < ptime_reg.idle_end;
  wire frame_start = rise_ev && timer_next == 8'h00;
  // ==========================================================================
  // Channel slots
  wire stream_src = cur_func == sbc_port_pkg::func_source || wbs_mode;
  wire stream_snk = cur_func == sbc_port_pkg::func_sink || wbs_mode;
  logic [1:0] ch_done;
  logic [1:0] ch_drive;
  logic [1:0] ch_bit;
  genvar c;
  generate
    for (c = 0; c < 2; c = c + 1) begin : g_chan
      logic [31:0] shift_reg;
      logic [31:0] out_reg;
      logic [31:0] tx_word_reg;
      logic done_reg;
      wire [8:0] end_pos = {1'b0, ch_reg[c].pos} + {3'b000, ch_reg[c].size};
      wire cap_in = {1'b0, cap_idx} >= {1'b0, ch_reg[c].pos} && {1'b0, cap_idx} < end_pos;
      wire cap_last = {1'b0, cap_idx} + 9'h001 == end_pos;
      wire drv_in = {1'b0, frame_bit_timer} >= {1'b0, ch_reg[c].pos} &&
        {1'b0, frame_bit_timer} < end_pos;
      wire [5:0] drv_off = 6'(frame_bit_timer - ch_reg[c].pos);
      wire [5:0] drv_sel = 6'(ch_reg[c].size - 6'h01 - drv_off);
      wire [31:0] shifted = {shift_reg[30:0], din_bit};
      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          shift_reg <= 32'h0000_0000;
          done_reg <= 1'b0;
          out_reg <= 32'h0000_0000;
        end else begin
          done_reg <= 1'b0;
          if (cap_ev && cap_in) begin
            shift_reg <= shifted; // R05
          end
          if (cap_ev && cap_last) begin
            done_reg <= 1'b1;
          end
          if (frame_start) begin
            out_reg <= tx_word_reg;
          end
        end
      end
      // Decoded samples replace the software word only while a decoding function runs.
      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          tx_word_reg <= 32'h0000_0000;
        end else if (stream_snk && dec_sample_valid && dec_sample_chan == c) begin
          tx_word_reg <= dec_sample_data; // R18
        end else if ((c == 0 && wr_tx0) || (c == 1 && wr_tx1)) begin
          tx_word_reg <= hwdata;
        end
      end
      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          rx_reg[c] <= 32'h0000_0000;
        end else if (cap_ev && cap_last) begin
          rx_reg[c] <= shifted;
        end
      end
      assign tx_reg[c] = tx_word_reg;
      assign ch_done[c] = done_reg;
      assign ch_drive[c] = drv_in;
      assign ch_bit[c] = out_reg[drv_sel[4:0]];
    end
  endgenerate
  // ==========================================================================
  // Pin drivers and sample hand-off to the coprocessor
  logic dout_reg;
  logic doe_reg;
  logic sync_out_reg;
  logic [31:0] enc_data_reg;
  logic enc_chan_reg;
  logic enc_valid_reg;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dout_reg <= 1'b0;
      doe_reg <= 1'b0;
      sync_out_reg <= 1'b0;
      enc_data_reg <= 32'h0000_0000;
      enc_chan_reg <= 1'b0;
      enc_valid_reg <= 1'b0;
    end else begin
      if (!pcfg_reg.enable) begin
        doe_reg <= 1'b0;
      end else if (launch_ev) begin
        doe_reg <= |ch_drive; // R05
        dout_reg <= (ch_drive[0] ? ch_bit[0] : ch_bit[1]) ^ pcfg_reg.data_inv;
      end
      if (launch_ev) begin
        sync_out_reg <= (frame_bit_timer == 8'h00) ^ pcfg_reg.sync_inv;
      end
      enc_valid_reg <= stream_src && (|ch_done); // R18
      if (|ch_done) begin
        enc_chan_reg <= ch_done[1];
        enc_data_reg <= ch_done[1] ? rx_reg[1] : rx_reg[0];
      end
    end
  end
  // The bit clock is held low through the idle window; slots are checked to end first on channel writes, not when idle_start is written.
  assign pcm_clk_out = phase_reg & ~in_idle; // R01
  assign pcm_clk_oe = pcfg_reg.enable & pcfg_reg.master;
  assign pcm_sync_out = sync_out_reg;
  assign pcm_sync_oe = pcfg_reg.enable & pcfg_reg.master;
  assign pcm_data_out = dout_reg;
  assign pcm_data_oe = doe_reg;
  assign enc_sample_data = enc_data_reg;
  assign enc_sample_chan = enc_chan_reg;
  assign enc_sample_valid = enc_valid_reg;
endmodule : sbc_port_engine

// ==== verilog/sbc_port_pkg.sv ====
// Constants and carrier types for the assisted subband codec engine and its audio port.
package sbc_port_pkg;
  // ==========================================================================
  // Register byte offsets
  localparam logic [7:0] port_cfg_off = 8'h00;
  localparam logic [7:0] port_time_off = 8'h04;
  localparam logic [7:0] ch0_cfg_off = 8'h08;
  localparam logic [7:0] ch1_cfg_off = 8'h0c;
  localparam logic [7:0] codec_cfg_off = 8'h10;
  localparam logic [7:0] mtu_off = 8'h14;
  localparam logic [7:0] status_off = 8'h18;
  localparam logic [7:0] rx0_off = 8'h1c;
  localparam logic [7:0] rx1_off = 8'h20;
  localparam logic [7:0] tx0_off = 8'h24;
  localparam logic [7:0] tx1_off = 8'h28;
  localparam logic [7:0] link_off = 8'h2c;
  // ==========================================================================
  // Function selection and field encodings
  localparam logic [2:0] func_none = 3'h0;
  localparam logic [2:0] func_le = 3'h1;
  localparam logic [2:0] func_wbs = 3'h2;
  localparam logic [2:0] func_sink = 3'h3;
  localparam logic [2:0] func_source = 3'h4;
  localparam logic [1:0] chmode_mono = 2'h0;
  localparam logic [1:0] fs_16k = 2'h0;
  localparam logic [1:0] fs_48k = 2'h2;
  localparam logic sub_8 = 1'b1;
  localparam logic alloc_loudness = 1'b1;
  localparam logic scheme_sbc = 1'b0;
  localparam logic [4:0] wbs_block_len = 5'h0f;
  localparam logic [7:0] wbs_bitpool = 8'h1a;
  localparam logic [7:0] bitpool_min = 8'h02;
  localparam logic [7:0] bitpool_max_sink = 8'h36;
  localparam logic [7:0] bitpool_max_source = 8'h39;
  localparam logic [10:0] mtu_min = 11'h104;
  localparam logic [10:0] mtu_max_sink = 11'h320;
  localparam logic [10:0] mtu_max_source = 11'h3fd;
  localparam logic [5:0] word_max = 6'h20;
  // ==========================================================================
  // Reset values
  localparam logic [7:0] clk_div_reset = 8'h04;
  localparam logic [7:0] frame_len_reset = 8'h40;
  // ==========================================================================
  // Carrier types
  typedef struct packed {
    logic [7:0] clk_div;
    logic data_inv;
    logic sync_inv;
    logic falling;
    logic master;
    logic enable;
  } port_cfg_type;
  typedef struct packed {
    logic [7:0] idle_end;
    logic [7:0] idle_start;
    logic [7:0] frame_len;
  } port_time_type;
  typedef struct packed {
    logic [7:0] pos;
    logic [5:0] size;
  } chan_cfg_type;
  typedef struct packed {
    logic [7:0] bitpool;
    logic scheme;
    logic alloc;
    logic sub;
    logic [1:0] blk;
    logic [1:0] fs;
    logic [1:0] chmode;
    logic [2:0] func;
  } codec_cfg_type;
endpackage : sbc_port_pkg

// ==== testbench/sbc_port_engine_chk.sv ====
// Concurrent checks on the ports of the subband codec engine.
`timescale 1ns/1ps
module sbc_port_engine_chk (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic enc_sample_valid,
  input wire sbc_port_pkg::codec_cfg_type codec_cfg,
  input wire logic [10:0] mtu_size
);
  // ==========================================================================
  // Helpers
  wire logic [2:0] fn = codec_cfg.func;
  wire logic snk = fn == sbc_port_pkg::func_sink;
  wire logic strm = snk || fn == sbc_port_pkg::func_source;
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // ==========================================================================
  // Assertions
  chk_resp_okay: assert property (hresp == 1'b0) else $error("error response seen");
  chk_read_wait: assert property (hsel && htrans[1] && hready && !hwrite |=>
    !hreadyout ##1 hreadyout) else $error("read wait state wrong");
  chk_wbs_fixed: assert property (fn == sbc_port_pkg::func_wbs |->
    codec_cfg.chmode == sbc_port_pkg::chmode_mono && codec_cfg.fs == sbc_port_pkg::fs_16k &&
    codec_cfg.alloc == sbc_port_pkg::alloc_loudness && codec_cfg.sub == sbc_port_pkg::sub_8 &&
    codec_cfg.bitpool == sbc_port_pkg::wbs_bitpool) else $error("wideband settings wrong");
  chk_scheme_only: assert property (strm |-> codec_cfg.scheme == sbc_port_pkg::scheme_sbc)
    else $error("foreign coding scheme held");
  chk_fs_legal: assert property (strm |-> codec_cfg.fs != 2'h3)
    else $error("illegal sampling rate held");
  chk_bitpool_span: assert property (strm |-> codec_cfg.bitpool >= sbc_port_pkg::bitpool_min &&
    codec_cfg.bitpool <= (snk ? sbc_port_pkg::bitpool_max_sink : sbc_port_pkg::bitpool_max_source))
    else $error("bitpool out of range");
  chk_mtu_span: assert property ($changed(mtu_size) |-> mtu_size >= sbc_port_pkg::mtu_min &&
    mtu_size <= (snk ? sbc_port_pkg::mtu_max_sink : sbc_port_pkg::mtu_max_source))
    else $error("transfer unit out of range");
  chk_func_via_none: assert property ($changed(fn) |->
    $past(fn) == sbc_port_pkg::func_none || fn == sbc_port_pkg::func_none)
    else $error("function switched directly");
  chk_enc_role: assert property (enc_sample_valid |->
    fn == sbc_port_pkg::func_source || fn == sbc_port_pkg::func_wbs)
    else $error("sample to encoder in wrong role");
endmodule : sbc_port_engine_chk
bind sbc_port_engine sbc_port_engine_chk chk_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
  .htrans(htrans), .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
  .enc_sample_valid(enc_sample_valid), .codec_cfg(codec_cfg), .mtu_size(mtu_size));

// ==== testbench/pcm_codec_model.sv ====
// Behavioural external codec that masters the audio bit clock and frame sync.
`timescale 1ns/1ps
module pcm_codec_model (
  output logic clk,
  output logic sync,
  output logic data,
  output logic busy,
  input wire logic run,
  input wire logic [31:0] word
);
  // ==========================================================================
  // Frame generator
  // The clock rests low between frames, as a codec that gates its clock does.
  initial begin
    clk = 1'b0;
    sync = 1'b0;
    data = 1'b0;
    busy = 1'b0;
  end
  always @(posedge run) begin
    busy = 1'b1;
    for (int i = 0; i < 64; i++) begin
      clk = 1'b0;
      sync = (i == 0);
      #200;
      clk = 1'b1;
      data = (i < 32) ? word[31 - i] : ~data;
      #200;
    end
    clk = 1'b0;
    busy = 1'b0;
  end
endmodule : pcm_codec_model

// ==== testbench/tb.sv ====
// Self-checking bench of the codec engine: registers, settings and the audio port.
`timescale 1ns/1ps
module tb;
  typedef struct packed {logic [7:0] a; logic [31:0] d; logic ok;} row_type;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic run = 1'b0;
  logic [31:0] word = 32'ha5c3_3c5a;
  logic [31:0] hrdata, q, rd_s, e1, enc_d, enc_last;
  logic hreadyout, hresp, rdy_s, pclk, psync, pdata, busy, enc_sample_valid;
  logic [10:0] mtu_size;
  sbc_port_pkg::codec_cfg_type codec_cfg;
  logic [31:0] shadow [0:15];
  int bad_count = 0;
  int checked = 0;
  int cyc = 0;
  int pulses = 0;
  row_type rows [0:25] = '{
    '{8'h10, 32'h2004, 1}, '{8'h10, 32'h396ac, 1}, '{8'h10, 32'h3a154, 0},
    '{8'h10, 32'h397dc, 1}, '{8'h10, 32'h397fc, 0}, '{8'h10, 32'h39fdc, 0},
    '{8'h10, 32'h17dc, 0}, '{8'h10, 32'h2003, 0}, '{8'h10, 32'h0, 1},
    '{8'h10, 32'h367db, 1}, '{8'h14, 32'h320, 1}, '{8'h14, 32'h321, 0},
    '{8'h14, 32'h103, 0}, '{8'h14, 32'h104, 1}, '{8'h10, 32'h377db, 0},
    '{8'h10, 32'h1, 0}, '{8'h10, 32'h0, 1}, '{8'h10, 32'h1a602, 1},
    '{8'h10, 32'h19602, 0}, '{8'h2c, 32'h1, 1}, '{8'h2c, 32'h3, 0},
    '{8'h2c, 32'h0, 1}, '{8'h10, 32'h0, 1}, '{8'h10, 32'h397dc, 1},
    '{8'h14, 32'h3fd, 1}, '{8'h14, 32'h3fe, 0}};
  logic [39:0] rst_tab [0:4] = '{40'h0000000400, 40'h0400000040, 40'h0c00001010,
    40'h1400000104, 40'h3000000000};
  sbc_port_engine dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .pcm_clk_in(pclk), .pcm_clk_out(),
    .pcm_clk_oe(), .pcm_sync_in(psync), .pcm_sync_out(), .pcm_sync_oe(), .pcm_data_in(pdata),
    .pcm_data_out(), .pcm_data_oe(), .enc_sample_data(enc_d), .enc_sample_chan(),
    .enc_sample_valid(enc_sample_valid), .dec_sample_data(32'h0), .dec_sample_chan(1'b0),
    .dec_sample_valid(1'b0), .codec_cfg(codec_cfg), .mtu_size(mtu_size));
  pcm_codec_model codec (.clk(pclk), .sync(psync), .data(pdata), .busy(busy), .run(run),
    .word(word));
  // ==========================================================================
  // Clock, sampling and timeout
  always #25 hclk = ~hclk;
  always @(posedge hclk) begin
    rdy_s <= hreadyout;
    rd_s <= hrdata;
    if (enc_sample_valid === 1'b1) pulses++;
    if (enc_sample_valid === 1'b1) enc_last <= enc_d;
    cyc++;
    if (cyc == 5000) begin
      bad_count++;
      conclude();
    end
  end
  // ==========================================================================
  // Tasks
  task automatic check(input string n, input logic [31:0] e, input logic [31:0] s);
    checked++;
    if (s !== e) begin
      bad_count++;
      $display("unexpected %s: expected %h seen %h", n, e, s);
    end
  endtask : check
  // Sampling one ns after the edge avoids racing the slave's own flops.
  task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d,
    output logic [31:0] r);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    do begin @(posedge hclk); #1; end while (rdy_s !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do begin @(posedge hclk); #1; end while (rdy_s !== 1'b1);
    r = rd_s;
  endtask : bus
  task automatic conclude();
    $display("checked %0d bad_count %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : conclude
  // ==========================================================================
  // Main sequence
  initial begin
    shadow[4] = 32'h0;
    shadow[5] = 32'h104;
    shadow[11] = 32'h0;
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    #1;
    bus(8'h30, 1'b1, 32'hffff_ffff, q);
    foreach (rst_tab[i]) begin
      bus(rst_tab[i][39:32], 1'b0, 32'h0, q);
      check("reset value", rst_tab[i][31:0], q);
    end
    foreach (rows[i]) begin
      bus(rows[i].a, 1'b1, rows[i].d, q);
      if (rows[i].ok) shadow[rows[i].a[5:2]] = rows[i].d;
      bus(rows[i].a, 1'b0, 32'h0, q);
      check("readback", shadow[rows[i].a[5:2]], q);
      bus(sbc_port_pkg::status_off, 1'b0, 32'h0, q);
      check("cfg_err", {31'h0, ~rows[i].ok}, {31'h0, q[0]});
      bus(sbc_port_pkg::status_off, 1'b1, 32'h1, q);
    end
    bus(8'h08, 1'b1, 32'h21, q);
    bus(8'h0c, 1'b1, 32'h1000, q);
    bus(8'h08, 1'b0, 32'h0, q);
    check("ch0 size", 32'h10, q);
    for (int k = 0; k < 2; k++) begin
      bus(8'h00, 1'b1, k ? 32'h415 : 32'h405, q);
      run <= 1'b1;
      while (busy !== 1'b1) @(posedge hclk);
      run <= 1'b0;
      while (busy !== 1'b0) @(posedge hclk);
      repeat (8) @(posedge hclk);
      #1;
      bus(8'h1c, 1'b0, 32'h0, q);
      check("rx0", k ? {word[31:16], ~word[31:16]} : {16'h0, word[31:16]}, q);
      bus(8'h20, 1'b0, 32'h0, q);
      e1 = k ? {word[15:0], ~word[15:0]} : {16'h0, word[15:0]};
      check("rx1", e1, q);
      check("encoder data", e1, enc_last);
      check("encoder words", 2 * k + 2, pulses);
    end
    bus(8'h04, 1'b1, 32'h1840, q);
    bus(8'h08, 1'b1, 32'h1010, q);
    bus(8'h08, 1'b0, 32'h0, q);
    check("ch0 idle", 32'h10, q);
    hresetn <= 1'b0;
    @(posedge hclk);
    #1;
    check("cfg after reset", 32'h0, {12'h0, codec_cfg});
    check("mtu after reset", 32'h104, {21'h0, mtu_size});
    conclude();
  end
endmodule : tb
